// *** hw/cfg_emul_map.svh ***
// offsets, field positions, reset values and timing counts of the
// configuration emulation block; assumes word-addressed Avalon-MM access.
`ifndef CFG_EMUL_MAP_SVH
`define CFG_EMUL_MAP_SVH

// ----------------------------------------------------------------------
// register word indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define CFG_REG_CONTROL      2'h0
`define CFG_REG_STATUS       2'h1
`define CFG_REG_DISCARD      2'h2

// ----------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------
`define CFG_CTL_MODE_LSB     0
`define CFG_CTL_MODE_MSB     2
`define CFG_CTL_DOWNSTREAM   3
`define CFG_CTL_RESET        32'h0000_0000

// ----------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------
`define CFG_ST_COMPLETE      0
`define CFG_ST_HELD_LOW      1
`define CFG_ST_USER_RUN      2
`define CFG_ST_LOAD_READY    3
`define CFG_ST_PASS_ON       4
`define CFG_ST_MODE_LSB      8
`define CFG_ST_MODE_MSB      10

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CFG_CLK_PERIOD_NS    100
`define CFG_PASS_DELAY_NS    200
`define CFG_PASS_CYCLES \
  ((`CFG_PASS_DELAY_NS + `CFG_CLK_PERIOD_NS - 1) / `CFG_CLK_PERIOD_NS)

`endif

// *** hw/cfg_emul_pkg.sv ***
// types shared by the configuration emulation block;
// assumes the constants of cfg_emul_map.svh.
package cfg_emul_pkg;

  // ----------------------------------------------------------------------
  // configuration modes
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    mode_master_serial   = 3'h0,
    mode_slave_serial    = 3'h1,
    mode_master_par_up   = 3'h2,
    mode_master_par_down = 3'h3,
    mode_async_periph    = 3'h4,
    mode_sync_periph     = 3'h5,
    mode_slave_par       = 3'h6,
    mode_reserved        = 3'h7
  } mode_t;

  // ----------------------------------------------------------------------
  // emulation state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    st_config = 2'h0,
    st_run    = 2'h1,
    st_reseq  = 2'h3
  } emul_state_t;

  // ----------------------------------------------------------------------
  // peripheral strobes as seen after synchronising
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic chip_select_low_n;
    logic chip_select_high;
    logic read_n;
    logic write_n;
  } strobe_t;

endpackage

// *** hw/sync2.sv ***
// two-stage synchroniser for a group of level inputs;
// assumes inputs are asynchronous to sys_clk.
module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  if (WIDTH < 1) begin : g_bad_width
    $error("sync2: WIDTH must be at least 1");
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1   <= INIT;
      sync_out <= INIT;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // sync2

// *** hw/pass_delay.sv ***
// fixed shift delay for the serial chain passthrough;
// assumes its input is already synchronous to sys_clk.
module pass_delay #(
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // serial data
  input  wire logic bit_in,
  output logic      bit_out
);

  logic [DEPTH-1:0] taps;
  logic [DEPTH-1:0] next_taps;

  if (DEPTH < 1) begin : g_bad_depth
    $error("pass_delay: DEPTH must be at least 1");
  end

  // each stage takes the one before it
  for (genvar i = 0; i < DEPTH; i++) begin : g_tap
    if (i == 0) begin : g_first
      always_comb next_taps[i] = bit_in;
    end else begin : g_rest
      always_comb next_taps[i] = taps[i-1];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      taps <= '0;
    end else begin
      taps <= next_taps;
    end
  end

  assign bit_out = taps[DEPTH-1];

endmodule // pass_delay

// *** hw/fpga_config_emulation.sv ***
// configuration handshake emulation for a fixed-logic replacement part;
// assumes an Avalon-MM master on sys_clk and asynchronous config pins.
//
// Summary of operation
// - master PROM modes: completion shows at once, no read cycles made.
// - reset pin leaves completion alone unless the build option asks.
// - peripheral, completion held low: handshake shown, words dropped.
// - completion not held low: completion true, user function runs.
// - serial or chained slave: chain data forwarded after fixed delay.
// - peripheral, slave parallel: load ready high while completion low.
// - master parallel: no config clock, address and data are user I/O.
// - peripheral and slave parallel: no config clock, no chain data out.
// - no configuration readback in any mode.
// - all-replacement chain: master emulates mode, downstream default.
// - completion low: init and high-during high, low-during low.
// - peripheral status read strobe puts load ready on data bit 7.
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`include "cfg_emul_map.svh"

module fpga_config_emulation
  import cfg_emul_pkg::*;
#(
  parameter bit RESET_RESEQUENCE = 1'b0,
  parameter int PASS_CYCLES      = `CFG_PASS_CYCLES
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [1:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // completion pin, open drain
  input  wire logic        config_complete_in,
  output logic             config_complete_out,
  output logic             config_complete_oe,
  // device reset pin
  input  wire logic        device_reset_n,
  // peripheral strobes
  input  wire logic        chip_select_low_n,
  input  wire logic        chip_select_high,
  input  wire logic        read_n,
  input  wire logic        write_n,
  // data bus
  output logic      [7:0]  config_data_out,
  output logic      [7:0]  config_data_oe,
  // configuration clock pin
  output logic             config_clock_out,
  output logic             config_clock_oe,
  // serial chain
  input  wire logic        chain_data_in,
  output logic             chain_data_out,
  output logic             chain_data_oe,
  // handshake outputs
  output logic             load_ready_flag,
  output logic             init_status,
  output logic             high_during_config,
  output logic             low_during_config,
  output logic             user_run
);

  if (PASS_CYCLES < 1) begin : g_bad_pass
    $error("fpga_config_emulation: PASS_CYCLES must be at least 1");
  end

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic    done_s;
  logic    dev_rst_n_s;
  logic    din_s;
  strobe_t strobe_s;

  sync2 #(
    .WIDTH (7),
    .INIT  (7'h7b)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in ({config_complete_in, device_reset_n, chain_data_in,
                chip_select_low_n, chip_select_high, read_n, write_n}),
    .sync_out ({done_s, dev_rst_n_s, din_s, strobe_s})
  );

  // ----------------------------------------------------------------------
  // chain passthrough
  // ----------------------------------------------------------------------
  logic din_delayed;

  pass_delay #(
    .DEPTH (PASS_CYCLES)
  ) u_pass (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .bit_in  (din_s),
    .bit_out (din_delayed)
  );

  // ----------------------------------------------------------------------
  // register file and bus slave
  // ----------------------------------------------------------------------
  mode_t       mode;
  logic        downstream;
  logic [15:0] discard_count;
  logic        wait_q;
  logic [31:0] rdata;
  mode_t       next_mode;
  logic        next_downstream;
  logic [15:0] next_discard_count;
  logic        next_wait_q;
  logic [31:0] next_rdata;
  logic        access;
  logic        word_taken;

  // ----------------------------------------------------------------------
  // emulation state
  // ----------------------------------------------------------------------
  emul_state_t state;
  emul_state_t next_state;
  logic        wr_active_q;
  logic        next_wr_active_q;

  mode_t eff_mode;
  logic  is_periph;
  logic  is_master_par;
  logic  pass_on;
  logic  wr_active;
  logic  status_rd;

  // downstream chain members fall back to default mode
  always_comb begin
    eff_mode = downstream ? mode_master_serial : mode;
    is_periph = (eff_mode == mode_async_periph) ||
                (eff_mode == mode_sync_periph) ||
                (eff_mode == mode_slave_par);
    is_master_par = (eff_mode == mode_master_par_up) ||
                    (eff_mode == mode_master_par_down);
    pass_on = (eff_mode == mode_slave_serial) || downstream;
    wr_active = !strobe_s.chip_select_low_n && strobe_s.chip_select_high &&
                !strobe_s.write_n;
    status_rd = !strobe_s.chip_select_low_n && strobe_s.chip_select_high &&
                !strobe_s.read_n && strobe_s.write_n;
  end

  always_comb begin
    next_state       = state;
    next_wr_active_q = wr_active;
    unique case (state)
      st_config: begin
        if (RESET_RESEQUENCE && !dev_rst_n_s) begin
          next_state = st_reseq;
        end else if (done_s) begin
          next_state = st_run;
        end
      end
      st_run: begin
        if (RESET_RESEQUENCE && !dev_rst_n_s) begin
          next_state = st_reseq;
        end else if (!done_s) begin
          next_state = st_config;
        end
      end
      st_reseq: begin
        if (dev_rst_n_s) begin
          next_state = st_config;
        end
      end
      default: next_state = st_config;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= st_config;
      wr_active_q <= 1'b0;
    end else begin
      state       <= next_state;
      wr_active_q <= next_wr_active_q;
    end
  end

  // a programming word ends each write strobe; it is counted, never kept
  assign word_taken = is_periph && (state == st_config) && !wr_active &&
                      wr_active_q;
  assign access = avs_read || avs_write;

  always_comb begin
    next_mode          = mode;
    next_downstream    = downstream;
    next_discard_count = discard_count;
    next_wait_q        = !(access && wait_q);
    next_rdata         = 32'h0000_0000;
    if (avs_write && !wait_q) begin
      unique case (avs_address)
        `CFG_REG_CONTROL: begin
          next_mode = mode_t'(
            avs_writedata[`CFG_CTL_MODE_MSB:`CFG_CTL_MODE_LSB]);
          next_downstream = avs_writedata[`CFG_CTL_DOWNSTREAM];
        end
        `CFG_REG_DISCARD: next_discard_count = 16'h0000;
        default: ;
      endcase
    end
    // a clear and an arriving word in the same cycle leave a count of one
    if (word_taken) begin
      next_discard_count = next_discard_count + 16'h0001;
    end
    if (avs_read && wait_q) begin
      unique case (avs_address)
        `CFG_REG_CONTROL: begin
          next_rdata[`CFG_CTL_MODE_MSB:`CFG_CTL_MODE_LSB] = mode;
          next_rdata[`CFG_CTL_DOWNSTREAM] = downstream;
        end
        `CFG_REG_STATUS: begin
          next_rdata[`CFG_ST_COMPLETE]   = done_s;
          next_rdata[`CFG_ST_HELD_LOW]   = (state != st_run);
          next_rdata[`CFG_ST_USER_RUN]   = (state == st_run);
          next_rdata[`CFG_ST_LOAD_READY] = is_periph && (state != st_run);
          next_rdata[`CFG_ST_PASS_ON]    = pass_on;
          next_rdata[`CFG_ST_MODE_MSB:`CFG_ST_MODE_LSB] = eff_mode;
        end
        `CFG_REG_DISCARD: next_rdata[15:0] = discard_count;
        default: next_rdata = 32'h0000_0000;
      endcase
    end else if (!wait_q) begin
      next_rdata = rdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode          <= mode_t'(3'(`CFG_CTL_RESET));
      downstream    <= 1'b0;
      discard_count <= 16'h0000;
      wait_q        <= 1'b1;
      rdata         <= 32'h0000_0000;
    end else begin
      mode          <= next_mode;
      downstream    <= next_downstream;
      discard_count <= next_discard_count;
      wait_q        <= next_wait_q;
      rdata         <= next_rdata;
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata;

  // ----------------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------------
  logic       next_done_oe;
  logic       next_load_ready;
  logic       next_init;
  logic       next_hdc;
  logic       next_ldc;
  logic       next_run;
  logic       next_chain_out;
  logic       next_chain_oe;
  logic [7:0] next_data_out;
  logic [7:0] next_data_oe;
  logic       done_oe_q;

  always_comb begin
    // completion is only pulled low by the reset resequence option;
    // in every other case the pin floats high at once
    next_done_oe = (next_state == st_reseq);
    next_load_ready = is_periph && !done_s;
    next_init = 1'b1;
    next_hdc = !done_s;
    next_ldc = done_s;
    next_run = done_s && (next_state == st_run);
    // peripheral modes never drive the chain
    next_chain_out = pass_on && !is_periph && din_delayed;
    next_chain_oe = pass_on && !is_periph;
    next_data_out = 8'h00;
    next_data_oe  = 8'h00;
    // master parallel leaves the bus to user logic; no readback anywhere
    if (is_periph && !is_master_par && status_rd) begin
      next_data_out[7] = next_load_ready;
      next_data_oe[7]  = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_oe_q          <= 1'b0;
      load_ready_flag    <= 1'b0;
      init_status        <= 1'b1;
      high_during_config <= 1'b0;
      low_during_config  <= 1'b1;
      user_run           <= 1'b0;
      chain_data_out     <= 1'b0;
      chain_data_oe      <= 1'b0;
      config_data_out    <= 8'h00;
      config_data_oe     <= 8'h00;
      config_complete_out <= 1'b0;
      config_clock_out   <= 1'b0;
      config_clock_oe    <= 1'b0;
    end else begin
      done_oe_q          <= next_done_oe;
      load_ready_flag    <= next_load_ready;
      init_status        <= next_init;
      high_during_config <= next_hdc;
      low_during_config  <= next_ldc;
      user_run           <= next_run;
      chain_data_out     <= next_chain_out;
      chain_data_oe      <= next_chain_oe;
      config_data_out    <= next_data_out;
      config_data_oe     <= next_data_oe;
      config_complete_out <= 1'b0;
      config_clock_out   <= 1'b0;
      config_clock_oe    <= 1'b0;
    end
  end

  assign config_complete_oe = done_oe_q;

endmodule // fpga_config_emulation

// *** test/fpga_config_emulation_sva.sv ***
// concurrent checks on the ports of the configuration emulation block;
// assumes one clock domain, sys_clk, and the active-low reset rst_n.
module fpga_config_emulation_sva
  import cfg_emul_pkg::*;
#(
  parameter bit RESET_RESEQUENCE = 1'b0,
  parameter int PASS_CYCLES      = 2
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // avalon-mm
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  // pins
  input wire logic       config_complete_oe,
  input wire logic [7:0] config_data_oe,
  input wire logic       config_clock_oe,
  input wire logic       chain_data_in,
  input wire logic       chain_data_out,
  input wire logic       chain_data_oe,
  // handshake outputs
  input wire logic       load_ready_flag,
  input wire logic       init_status,
  input wire logic       high_during_config,
  input wire logic       low_during_config,
  input wire logic       user_run
);
  timeunit 1ns;
  timeprecision 1ns;

  localparam int LAT = PASS_CYCLES + 3;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_answer_next: assert property
    ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  a_clock_undriven: assert property
    (!config_clock_oe)
    else $error("config clock driven");
  a_init_high: assert property (init_status)
    else $error("init status low");
  a_config_levels: assert property
    (high_during_config == !low_during_config)
    else $error("high and low during config not opposite");
  a_ready_in_config: assert property
    (load_ready_flag |-> high_during_config)
    else $error("load ready outside configuration");
  a_run_needs_done: assert property
    (user_run |-> low_during_config)
    else $error("user logic runs while completion low");
  a_done_kept: assert property
    (!RESET_RESEQUENCE |-> !config_complete_oe)
    else $error("completion pulled low without build option");
  a_data_bit7_only: assert property
    (config_data_oe[6:0] == 7'h00)
    else $error("data bus driven beyond bit 7");
  a_chain_forward: assert property
    (chain_data_oe && $past(chain_data_oe, LAT)
     |-> chain_data_out == $past(chain_data_in, LAT))
    else $error("chain data not forwarded after fixed delay");
  a_chain_off_ready: assert property
    (load_ready_flag |-> !chain_data_oe)
    else $error("chain output driven in peripheral load");

  // ----------------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------------
  c_load_ready: cover property (load_ready_flag);
  c_chain_on: cover property (chain_data_oe);
  c_status_bit: cover property (config_data_oe[7]);

endmodule // fpga_config_emulation_sva

bind fpga_config_emulation fpga_config_emulation_sva #(
  .RESET_RESEQUENCE(RESET_RESEQUENCE),
  .PASS_CYCLES     (PASS_CYCLES)
) u_sva (
  .sys_clk, .rst_n, .avs_read, .avs_write, .avs_waitrequest,
  .config_complete_oe, .config_data_oe, .config_clock_oe,
  .chain_data_in, .chain_data_out, .chain_data_oe, .load_ready_flag,
  .init_status, .high_during_config, .low_during_config, .user_run
);

// *** test/config_host_model.sv ***
// far side of the configuration pins: host strobes, completion pull-up
// and the upstream chain; assumes the bench commands it on sys_clk edges.
module config_host_model
  import cfg_emul_pkg::*;
(
  // commands from the bench
  input  wire logic    hold_low,
  input  wire strobe_t host_strobe,
  input  wire logic    serial_bit,
  // device side of the open-drain completion
  input  wire logic    complete_out,
  input  wire logic    complete_oe,
  // pins toward the device
  output logic         config_complete_in,
  output logic         chip_select_low_n,
  output logic         chip_select_high,
  output logic         read_n,
  output logic         write_n,
  output logic         chain_data_in
);
  timeunit 1ns;
  timeprecision 1ns;

  // pull-up; the host holds it low for a whole load, else accepts it high
  assign config_complete_in =
    !(hold_low || (complete_oe && !complete_out));
  // host strobes are plain levels
  assign chip_select_low_n = host_strobe.chip_select_low_n;
  assign chip_select_high  = host_strobe.chip_select_high;
  assign read_n            = host_strobe.read_n;
  assign write_n           = host_strobe.write_n;
  // upstream real master shifts its trimmed stream
  assign chain_data_in = serial_bit;
endmodule // config_host_model

// *** test/fpga_config_emulation_tb.sv ***
// self-checking bench for the configuration emulation block;
// assumes the host model on the pins and an avalon-mm master here.
`include "cfg_emul_map.svh"

module fpga_config_emulation_tb
  import cfg_emul_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int PASS = 2;
  localparam int LAT  = PASS + 3;
  localparam logic [15:0] PAT = 16'h35c9;
  localparam strobe_t IDLE = '{1'b1, 1'b0, 1'b1, 1'b1};

  // clock, reset, bus
  logic        sys_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [1:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  // pins
  logic        cc_in, cc_out, cc_oe, device_reset_n, cs_low_n, cs_high;
  logic        read_n, write_n, clk_out, clk_oe, chain_in, chain_out;
  logic        chain_oe, load_ready_flag, init_status, user_run;
  logic        high_during_config, low_during_config;
  logic [7:0]  data_out, data_oe;
  // host commands
  logic        hold_low, serial_bit;
  strobe_t     host_strobe;
  int          miscompares, comparisons;

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = !sys_clk;
  end

  fpga_config_emulation #(.RESET_RESEQUENCE(1'b0), .PASS_CYCLES(PASS)) dut_u (
    .sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .config_complete_in(cc_in),
    .config_complete_out(cc_out), .config_complete_oe(cc_oe),
    .device_reset_n, .chip_select_low_n(cs_low_n),
    .chip_select_high(cs_high), .read_n, .write_n,
    .config_data_out(data_out), .config_data_oe(data_oe),
    .config_clock_out(clk_out), .config_clock_oe(clk_oe),
    .chain_data_in(chain_in), .chain_data_out(chain_out),
    .chain_data_oe(chain_oe), .load_ready_flag, .init_status,
    .high_during_config, .low_during_config, .user_run);

  config_host_model host_u (
    .hold_low, .host_strobe, .serial_bit, .complete_out(cc_out),
    .complete_oe(cc_oe), .config_complete_in(cc_in),
    .chip_select_low_n(cs_low_n), .chip_select_high(cs_high), .read_n,
    .write_n, .chain_data_in(chain_in));

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic complete_run;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] act, input logic [31:0] exp);
    comparisons++;
    if (act !== exp) begin
      miscompares++;
      $display("FAIL t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [1:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    r = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 40) begin
      miscompares++;
      complete_run();
    end
  endtask

  // pin-derived outputs need three edges
  task automatic settle;
    repeat (4) @(posedge sys_clk);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    miscompares = 0;
    comparisons = 0;
    rst_n = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {hold_low, serial_bit} = 2'b00;
    device_reset_n = 1'b1;
    host_strobe = IDLE;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    settle();
    // default mode, completion released
    check(user_run, 1'b1);
    check(cc_in, 1'b1);
    check({init_status, high_during_config,
           low_during_config}, 3'h5);
    bus(1'b0, `CFG_REG_STATUS, '0, q);
    check(q & 32'h0000_070f,
          (1 << `CFG_ST_COMPLETE) | (1 << `CFG_ST_USER_RUN));
    bus(1'b0, 2'h3, '0, q);
    check(q, 32'h0000_0000);
    // master parallel ignores a status read strobe
    host_strobe <= '{1'b0, 1'b1, 1'b0, 1'b1};
    for (int m = 2; m <= 3; m++) begin
      bus(1'b1, `CFG_REG_CONTROL, 32'(m), q);
      bus(1'b0, `CFG_REG_CONTROL, '0, q);
      check(q, 32'(m));
      settle();
      check({clk_oe, clk_out, cc_out, data_oe}, 11'h000);
    end
    host_strobe <= IDLE;
    device_reset_n <= 1'b0;
    settle();
    check({cc_in, user_run}, 2'h3);
    device_reset_n <= 1'b1;
    $display("test default done");
    // peripheral modes with completion held low
    hold_low <= 1'b1;
    for (int m = 4; m <= 6; m++) begin
      bus(1'b1, `CFG_REG_CONTROL, 32'(m), q);
      settle();
      check({load_ready_flag, user_run,
             chain_oe, clk_oe}, 4'h8);
      check({high_during_config, low_during_config}, 2'h2);
    end
    bus(1'b1, `CFG_REG_CONTROL, 32'h0000_0004, q);
    for (int w = 0; w < 3; w++) begin
      host_strobe <= '{1'b0, 1'b1, 1'b1, 1'b0};
      settle();
      host_strobe <= IDLE;
      settle();
    end
    bus(1'b0, `CFG_REG_DISCARD, '0, q);
    check(q & 32'h0000_ffff, 32'h0000_0003);
    bus(1'b1, `CFG_REG_DISCARD, '0, q);
    bus(1'b0, `CFG_REG_DISCARD, '0, q);
    check(q, 32'h0000_0000);
    host_strobe <= '{1'b0, 1'b1, 1'b0, 1'b1};
    settle();
    check({data_oe[7], data_out[7]}, 2'h3);
    host_strobe <= IDLE;
    bus(1'b0, `CFG_REG_STATUS, '0, q);
    check(q & 32'h0000_070f,
          (4 << `CFG_ST_MODE_LSB) | (1 << `CFG_ST_HELD_LOW) |
          (1 << `CFG_ST_LOAD_READY));
    hold_low <= 1'b0;
    settle();
    check({cc_in, user_run, load_ready_flag}, 3'h6);
    $display("test peripheral done");
    // slave serial passthrough
    bus(1'b1, `CFG_REG_CONTROL, 32'h0000_0001, q);
    settle();
    check(chain_oe, 1'b1);
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      serial_bit <= PAT[i];
      if (i > LAT) begin
        check(chain_out, PAT[i-LAT-1]);
      end
    end
    $display("test chain done");
    // downstream member falls back to default mode, keeps passthrough
    bus(1'b1, `CFG_REG_CONTROL, 32'h0000_000c, q);
    hold_low <= 1'b1;
    settle();
    check({load_ready_flag, chain_oe}, 2'h1);
    hold_low <= 1'b0;
    settle();
    bus(1'b0, `CFG_REG_STATUS, '0, q);
    check(q & 32'h0000_071f,
          (1 << `CFG_ST_COMPLETE) | (1 << `CFG_ST_USER_RUN) |
          (1 << `CFG_ST_PASS_ON));
    $display("test downstream done");
    complete_run();
  end
endmodule // fpga_config_emulation_tb
